/* File: rtl/gpio_rail_ctrl.sv */
// Functional notes
// - phase offset in 90 or 120 degree steps
// - any pin selectable as external clock input, except pins 4 and 5 in serial mode
// - config loads from otp or serial writes
// - six polarity bits invert pin active level
// - serial mode ignores polarity bits 5 and 4
// - rail enable pin maps any rail mix
// - enable pin asserted enables, deasserted disables rails
// - host commands rail enables independently too
// - power good asserts when all mapped rails good
// - per-rail power good readable by host
// - event pin signals exactly one selected condition
// - serial slave address from nonvolatile memory
// - every config and status readable serially
`timescale 1ns/10ps
module gpio_rail_ctrl (
	// clocks and reset
	input  wire logic                         clock_in,
	input  wire logic                         rst_in,
	input  wire logic                         ext_clk_in,
	// two-wire serial slave
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe_out,
	// general-purpose pins
	input  wire logic [5:0]                   gpio_in,
	output logic [5:0]                        gpio_out,
	output logic [5:0]                        gpio_oe_out,
	// nonvolatile configuration
	input  wire logic                         otp_load_in,
	input  wire logic [5:0]                   otp_polarity_in,
	input  wire gpio_rail_pkg::pin_cfg_s [5:0] otp_pin_cfg_in,
	input  wire logic [6:0]                   otp_slave_addr_in,
	input  wire logic                         serial_mode_in,
	// regulator side
	input  wire logic [4:0]                   rail_good_in,
	input  wire gpio_rail_pkg::event_vec_s    events_in,
	output logic [4:0]                        rail_enable_out,
	output logic [3:0][8:0]                   phase_deg_out,
	output logic [2:0]                        ext_clk_pin_out,
	output logic                              ext_clk_req_out
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} bus_state_e;

	function automatic logic is_out_fn(input logic [2:0] fn);
		is_out_fn = (fn == gpio_rail_pkg::FN_OUTPUT) || (fn == gpio_rail_pkg::FN_PWR_GOOD) ||
		            (fn == gpio_rail_pkg::FN_EVENT);
	endfunction : is_out_fn

	// synchronisers
	logic [5:0] gpio_s1_ff, gpio_s2_ff;
	logic [2:0] scl_sync_ff, sda_sync_ff;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gpio_s1_ff  <= 6'h00;
			gpio_s2_ff  <= 6'h00;
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
		end else begin
			gpio_s1_ff  <= gpio_in;
			gpio_s2_ff  <= gpio_s1_ff;
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
	assign sda_now   = sda_sync_ff[1];
	assign scl_rise  = scl_sync_ff[1] & ~scl_sync_ff[2];
	assign scl_fall  = ~scl_sync_ff[1] & scl_sync_ff[2];
	assign bus_start = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
	assign bus_stop  = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];

	// configuration registers
	logic [5:0]                    pol_ff;
	gpio_rail_pkg::pin_cfg_s [5:0] cfg_ff;
	logic [5:0]                    out_level_ff;
	logic [4:0]                    host_rail_en_ff;
	logic [7:0]                    phase_sel_ff;
	logic                          three_phase_ff;
	logic [6:0]                    slave_addr_ff;
	logic                          wr_pulse_ff;
	logic [7:0]                    wr_addr_ff, wr_data_ff;

	// an otp load in the same cycle as a serial write takes priority
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pol_ff          <= gpio_rail_pkg::POL_RESET;
			cfg_ff          <= {6{gpio_rail_pkg::CFG_RESET}};
			out_level_ff    <= 6'h00;
			host_rail_en_ff <= 5'h00;
			phase_sel_ff    <= gpio_rail_pkg::PHASE_SEL_RESET;
			three_phase_ff  <= 1'b0;
			slave_addr_ff   <= gpio_rail_pkg::SLAVE_ADDR_RESET;
		end else if (otp_load_in) begin
			pol_ff        <= otp_polarity_in;
			cfg_ff        <= otp_pin_cfg_in;
			slave_addr_ff <= otp_slave_addr_in;
		end else if (wr_pulse_ff) begin
			if (wr_addr_ff == gpio_rail_pkg::REG_POLARITY) begin
				pol_ff[3:0] <= wr_data_ff[3:0];
				if (!serial_mode_in) begin
					pol_ff[5:4] <= wr_data_ff[5:4];
				end
			end
			if (wr_addr_ff >= gpio_rail_pkg::REG_FUNC_BASE &&
			    wr_addr_ff <= gpio_rail_pkg::REG_FUNC_LAST) begin
				cfg_ff[3'(wr_addr_ff - gpio_rail_pkg::REG_FUNC_BASE)] <= wr_data_ff;
			end
			if (wr_addr_ff == gpio_rail_pkg::REG_OUT_LEVEL) begin
				out_level_ff <= wr_data_ff[5:0];
			end
			if (wr_addr_ff == gpio_rail_pkg::REG_HOST_RAIL_EN) begin
				host_rail_en_ff <= wr_data_ff[4:0];
			end
			if (wr_addr_ff == gpio_rail_pkg::REG_PHASE_SEL) begin
				phase_sel_ff <= wr_data_ff;
			end
			if (wr_addr_ff == gpio_rail_pkg::REG_PHASE_MODE) begin
				three_phase_ff <= wr_data_ff[0];
			end
		end
	end

	// pin functions; the internal side is always active high
	logic [5:0] pin_act;
	logic [5:0] int_out;
	logic [5:0] pin_is_out;
	logic [5:0] pin_oe_allow;
	logic [4:0] pin_rail_req [6];
	logic [5:0] pin_is_clk;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			logic [2:0] fn;
			logic [4:0] sel;
			assign fn  = cfg_ff[gi].func;
			assign sel = cfg_ff[gi].sel;
			assign pin_act[gi]      = gpio_s2_ff[gi] ^ pol_ff[gi];
			assign pin_oe_allow[gi] = !(serial_mode_in && gi >= gpio_rail_pkg::SERIAL_PIN_LO);
			assign pin_is_out[gi]   = is_out_fn(fn) && pin_oe_allow[gi];
			assign pin_is_clk[gi]   = (fn == gpio_rail_pkg::FN_EXT_CLK) && pin_oe_allow[gi];
			assign pin_rail_req[gi] = (fn == gpio_rail_pkg::FN_RAIL_EN && pin_oe_allow[gi] &&
			                           pin_act[gi]) ? sel : 5'h00;
			always_comb begin
				int_out[gi] = 1'b0;
				if (fn == gpio_rail_pkg::FN_OUTPUT) begin
					int_out[gi] = out_level_ff[gi];
				end else if (fn == gpio_rail_pkg::FN_PWR_GOOD) begin
					int_out[gi] = (sel != 5'h00) && ((rail_good_in & sel) == sel);
				end else if (fn == gpio_rail_pkg::FN_EVENT) begin
					int_out[gi] = (sel < 5'(gpio_rail_pkg::NUM_EVENTS)) &&
					              events_in[sel];
				end
			end
		end
	endgenerate

	logic [4:0] nxt_rail_en;
	logic [2:0] nxt_clk_pin;
	always_comb begin
		nxt_rail_en = host_rail_en_ff;
		nxt_clk_pin = 3'h0;
		for (int k = 0; k < 6; k++) begin
			nxt_rail_en = nxt_rail_en | pin_rail_req[k];
		end
		for (int k = 5; k >= 0; k--) begin
			if (pin_is_clk[k]) begin
				nxt_clk_pin = 3'(k);
			end
		end
	end

	logic [5:0] in_level_ff;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gpio_out        <= 6'h00;
			gpio_oe_out     <= 6'h00;
			rail_enable_out <= 5'h00;
			in_level_ff     <= 6'h00;
			ext_clk_pin_out <= 3'h0;
			ext_clk_req_out <= 1'b0;
		end else begin
			gpio_out        <= int_out ^ pol_ff;
			gpio_oe_out     <= pin_is_out;
			rail_enable_out <= nxt_rail_en;
			in_level_ff     <= pin_act;
			ext_clk_pin_out <= nxt_clk_pin;
			ext_clk_req_out <= |pin_is_clk;
		end
	end

	// phase offsets; selector 3 is not a legal step in three-phase use and yields zero
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			phase_deg_out <= '0;
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (three_phase_ff) begin
					phase_deg_out[c] <= (phase_sel_ff[2*c +: 2] == 2'h3) ? 9'h000 :
					   9'(phase_sel_ff[2*c +: 2] * gpio_rail_pkg::PHASE_STEP_THREE);
				end else begin
					phase_deg_out[c] <= 9'(phase_sel_ff[2*c +: 2] *
					                       gpio_rail_pkg::PHASE_STEP_FOUR);
				end
			end
		end
	end

	// external clock activity, measured from the core domain
	logic [7:0] gray_link;
	logic [7:0] gray_s1_ff, gray_s2_ff;
	logic [7:0] gray_bin, win_start_ff, ext_cnt_ff;
	logic [7:0] win_ff;

	ext_clk_counter #(.WIDTH(gpio_rail_pkg::GRAY_W)) u_ext_cnt (
		.ext_clk_in     (ext_clk_in),
		.rst_in         (rst_in),
		.gray_count_out (gray_link)
	);

	always_comb begin
		gray_bin[7] = gray_s2_ff[7];
		for (int b = 6; b >= 0; b--) begin
			gray_bin[b] = gray_bin[b+1] ^ gray_s2_ff[b];
		end
	end

	// the window is short enough that the count cannot wrap at the bench link rate
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gray_s1_ff   <= 8'h00;
			gray_s2_ff   <= 8'h00;
			win_ff       <= 8'h00;
			win_start_ff <= 8'h00;
			ext_cnt_ff   <= 8'h00;
		end else begin
			gray_s1_ff <= gray_link;
			gray_s2_ff <= gray_s1_ff;
			win_ff     <= win_ff + 8'h01;
			if (win_ff == gpio_rail_pkg::EXT_WINDOW_LAST) begin
				ext_cnt_ff   <= gray_bin - win_start_ff;
				win_start_ff <= gray_bin;
			end
		end
	end

	// register read mux
	bus_state_e state_ff;
	logic [7:0] ptr_ff;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	assign rd_addr = (state_ff == ST_RDATA_ACK) ? ptr_ff + 8'h01 : ptr_ff;

	always_comb begin
		rd_data = 8'h00;
		if (rd_addr >= gpio_rail_pkg::REG_FUNC_BASE && rd_addr <= gpio_rail_pkg::REG_FUNC_LAST) begin
			rd_data = cfg_ff[3'(rd_addr - gpio_rail_pkg::REG_FUNC_BASE)];
		end else begin
			unique case (rd_addr)
				gpio_rail_pkg::REG_POLARITY:     rd_data = {2'h0, pol_ff};
				gpio_rail_pkg::REG_OUT_LEVEL:    rd_data = {2'h0, out_level_ff};
				gpio_rail_pkg::REG_IN_LEVEL:     rd_data = {2'h0, in_level_ff};
				gpio_rail_pkg::REG_HOST_RAIL_EN: rd_data = {3'h0, host_rail_en_ff};
				gpio_rail_pkg::REG_RAIL_EN_STAT: rd_data = {3'h0, rail_enable_out};
				gpio_rail_pkg::REG_RAIL_GOOD:    rd_data = {3'h0, rail_good_in};
				gpio_rail_pkg::REG_EVENT_LO:     rd_data = events_in[7:0];
				gpio_rail_pkg::REG_EVENT_MID:    rd_data = events_in[15:8];
				gpio_rail_pkg::REG_EVENT_HI:     rd_data = {6'h00, events_in[17:16]};
				gpio_rail_pkg::REG_PHASE_SEL:    rd_data = phase_sel_ff;
				gpio_rail_pkg::REG_PHASE_MODE:   rd_data = {7'h00, three_phase_ff};
				gpio_rail_pkg::REG_EXT_CLK_STAT: rd_data = {3'h0, ext_clk_req_out, 1'b0,
				                                            ext_clk_pin_out};
				gpio_rail_pkg::REG_EXT_CLK_CNT:  rd_data = ext_cnt_ff;
				gpio_rail_pkg::REG_SLAVE_ADDR:   rd_data = {1'b0, slave_addr_ff};
				default:                         rd_data = 8'h00;
			endcase
		end
	end

	// two-wire slave engine; open drain, so only the enable moves
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [3:0] bit_cnt_ff;
	logic       rw_ff, mack_ff;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff    <= ST_IDLE;
			shift_ff    <= 8'h00;
			tx_ff       <= 8'h00;
			bit_cnt_ff  <= 4'h0;
			rw_ff       <= 1'b0;
			mack_ff     <= 1'b0;
			ptr_ff      <= 8'h00;
			sda_oe_out  <= 1'b0;
			sda_out     <= 1'b0;
			wr_pulse_ff <= 1'b0;
			wr_addr_ff  <= 8'h00;
			wr_data_ff  <= 8'h00;
		end else begin
			wr_pulse_ff <= 1'b0;
			if (bus_stop) begin
				state_ff   <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else if (bus_start) begin
				state_ff   <= ST_ADDR;
				bit_cnt_ff <= 4'h0;
				sda_oe_out <= 1'b0;
			end else if (scl_rise) begin
				if (state_ff == ST_ADDR || state_ff == ST_CMD || state_ff == ST_WDATA ||
				    state_ff == ST_RDATA) begin
					shift_ff   <= {shift_ff[6:0], sda_now};
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end
				if (state_ff == ST_RDATA_ACK) begin
					mack_ff <= ~sda_now;
				end
			end else if (scl_fall) begin
				unique case (state_ff)
					ST_IDLE: begin
					end
					ST_ADDR: if (bit_cnt_ff == 4'h8) begin
						if (shift_ff[7:1] == slave_addr_ff) begin
							rw_ff      <= shift_ff[0];
							state_ff   <= ST_ADDR_ACK;
							sda_oe_out <= 1'b1;
						end else begin
							state_ff <= ST_IDLE;
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt_ff <= 4'h0;
						if (rw_ff) begin
							state_ff   <= ST_RDATA;
							tx_ff      <= rd_data;
							sda_oe_out <= ~rd_data[7];
						end else begin
							state_ff   <= ST_CMD;
							sda_oe_out <= 1'b0;
						end
					end
					ST_CMD: if (bit_cnt_ff == 4'h8) begin
						ptr_ff     <= shift_ff;
						state_ff   <= ST_CMD_ACK;
						sda_oe_out <= 1'b1;
					end
					ST_CMD_ACK, ST_WDATA_ACK: begin
						if (state_ff == ST_WDATA_ACK) begin
							ptr_ff <= ptr_ff + 8'h01;
						end
						state_ff   <= ST_WDATA;
						bit_cnt_ff <= 4'h0;
						sda_oe_out <= 1'b0;
					end
					ST_WDATA: if (bit_cnt_ff == 4'h8) begin
						wr_pulse_ff <= 1'b1;
						wr_addr_ff  <= ptr_ff;
						wr_data_ff  <= shift_ff;
						state_ff    <= ST_WDATA_ACK;
						sda_oe_out  <= 1'b1;
					end
					ST_RDATA: begin
						if (bit_cnt_ff == 4'h8) begin
							state_ff   <= ST_RDATA_ACK;
							sda_oe_out <= 1'b0;
						end else begin
							tx_ff      <= {tx_ff[6:0], 1'b0};
							sda_oe_out <= ~tx_ff[6];
						end
					end
					ST_RDATA_ACK: begin
						if (mack_ff) begin
							ptr_ff     <= ptr_ff + 8'h01;
							tx_ff      <= rd_data;
							sda_oe_out <= ~rd_data[7];
							bit_cnt_ff <= 4'h0;
							state_ff   <= ST_RDATA;
						end else begin
							state_ff <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	property p_pol_guard;
		wr_pulse_ff && !otp_load_in && serial_mode_in && wr_addr_ff == 8'h00
			|=> $stable(pol_ff[5:4]);
	endproperty
	a_pol_guard: assert property (p_pol_guard) else $error("pol 5:4 changed");

	property p_pol_low;
		wr_pulse_ff && !otp_load_in && wr_addr_ff == 8'h00 |=> pol_ff[3:0] == $past(wr_data_ff[3:0]);
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("pol write lost");

	property p_otp;
		otp_load_in |=> pol_ff == $past(otp_polarity_in) && slave_addr_ff == $past(otp_slave_addr_in);
	endproperty
	a_otp: assert property (p_otp) else $error("otp load missed");

	property p_host_rail;
		##1 (rail_enable_out & $past(host_rail_en_ff)) == $past(host_rail_en_ff);
	endproperty
	a_host_rail: assert property (p_host_rail) else $error("host enable missing");

	property p_rail_off;
		host_rail_en_ff == 5'h00 && (pin_rail_req[0] | pin_rail_req[1] | pin_rail_req[2] |
		pin_rail_req[3] | pin_rail_req[4] | pin_rail_req[5]) == 5'h00 |=> rail_enable_out == 5'h00;
	endproperty
	a_rail_off: assert property (p_rail_off) else $error("rail left enabled");

	property p_rail_pin;
		cfg_ff[0].func == 3'h2 && (gpio_s2_ff[0] ^ pol_ff[0])
			|=> (rail_enable_out & $past(cfg_ff[0].sel)) == $past(cfg_ff[0].sel);
	endproperty
	a_rail_pin: assert property (p_rail_pin) else $error("pin enable missed");

	property p_pgood;
		cfg_ff[1].func == 3'h3 && (rail_good_in & cfg_ff[1].sel) != cfg_ff[1].sel
			|=> gpio_out[1] == $past(pol_ff[1]);
	endproperty
	a_pgood: assert property (p_pgood) else $error("power good too early");

	property p_event;
		cfg_ff[2].func == 3'h4 && cfg_ff[2].sel == 5'h08
			|=> gpio_out[2] == ($past(events_in.ovp_fault[0]) ^ $past(pol_ff[2]));
	endproperty
	a_event: assert property (p_event) else $error("event pin wrong");

	property p_phase3;
		three_phase_ff ##1 three_phase_ff |-> phase_deg_out[0] <= 9'h0F0;
	endproperty
	a_phase3: assert property (p_phase3) else $error("phase out of range");

	property p_nack;
		scl_fall && state_ff == ST_ADDR && bit_cnt_ff == 4'h8 && !bus_start && !bus_stop &&
		shift_ff[7:1] != slave_addr_ff |=> !sda_oe_out && state_ff == ST_IDLE;
	endproperty
	a_nack: assert property (p_nack) else $error("foreign address acked");

	property p_clk_pin;
		cfg_ff[3].func == 3'h5 |=> !gpio_oe_out[3];
	endproperty
	a_clk_pin: assert property (p_clk_pin) else $error("clock pin driven");

	c_write: cover property (wr_pulse_ff ##1 state_ff == ST_WDATA_ACK);
	c_read: cover property (state_ff == ST_RDATA_ACK ##1 state_ff == ST_RDATA);
	c_ext_clk: cover property (ext_clk_req_out && ext_cnt_ff != 8'h00);
	c_pgood: cover property (cfg_ff[1].func == 3'h3 && gpio_out[1] != pol_ff[1]);

endmodule : gpio_rail_ctrl

/* File: rtl/gpio_rail_pkg.sv */
package gpio_rail_pkg;

	// sizes
	localparam int NUM_PINS   = 6;
	localparam int NUM_RAILS  = 5;
	localparam int NUM_CH     = 4;
	localparam int NUM_EVENTS = 18;
	localparam int GRAY_W     = 8;

	// register offsets, reached through the command byte of a serial write
	localparam logic [7:0] REG_POLARITY     = 8'h00;
	localparam logic [7:0] REG_FUNC_BASE    = 8'h01;
	localparam logic [7:0] REG_FUNC_LAST    = 8'h06;
	localparam logic [7:0] REG_OUT_LEVEL    = 8'h07;
	localparam logic [7:0] REG_IN_LEVEL     = 8'h08;
	localparam logic [7:0] REG_HOST_RAIL_EN = 8'h09;
	localparam logic [7:0] REG_RAIL_EN_STAT = 8'h0A;
	localparam logic [7:0] REG_RAIL_GOOD    = 8'h0B;
	localparam logic [7:0] REG_EVENT_LO     = 8'h0C;
	localparam logic [7:0] REG_EVENT_MID    = 8'h0D;
	localparam logic [7:0] REG_EVENT_HI     = 8'h0E;
	localparam logic [7:0] REG_PHASE_SEL    = 8'h0F;
	localparam logic [7:0] REG_PHASE_MODE   = 8'h10;
	localparam logic [7:0] REG_EXT_CLK_STAT = 8'h11;
	localparam logic [7:0] REG_EXT_CLK_CNT  = 8'h12;
	localparam logic [7:0] REG_SLAVE_ADDR   = 8'h13;

	// pin function codes held in the top bits of each pin config byte
	localparam logic [2:0] FN_INPUT    = 3'h0;
	localparam logic [2:0] FN_OUTPUT   = 3'h1;
	localparam logic [2:0] FN_RAIL_EN  = 3'h2;
	localparam logic [2:0] FN_PWR_GOOD = 3'h3;
	localparam logic [2:0] FN_EVENT    = 3'h4;
	localparam logic [2:0] FN_EXT_CLK  = 3'h5;

	// serial-bus pins shared with gpio 4 and 5
	localparam int SERIAL_PIN_LO = 4;

	// reset values
	localparam logic [5:0] POL_RESET        = 6'h00;
	localparam logic [7:0] CFG_RESET        = 8'h00;
	localparam logic [7:0] PHASE_SEL_RESET  = 8'hE4;
	localparam logic [6:0] SLAVE_ADDR_RESET = 7'h20; // arbitrary default

	// phase steps in degrees
	localparam logic [8:0] PHASE_STEP_FOUR  = 9'h05A;
	localparam logic [8:0] PHASE_STEP_THREE = 9'h078;

	// ext clock measurement window in core cycles
	localparam logic [7:0] EXT_WINDOW_LAST = 8'hFF;

	typedef struct packed {
		logic [2:0] func;
		logic [4:0] sel;
	} pin_cfg_s;

	// sel code 0 is ocp_fault[0]; last member sits at the low bits
	typedef struct packed {
		logic       ot_warn;
		logic       ot_fault;
		logic [1:0] uv_warn;
		logic [1:0] uv_fault;
		logic [3:0] ovp_fault;
		logic [3:0] ocp_warn;
		logic [3:0] ocp_fault;
	} event_vec_s;

endpackage : gpio_rail_pkg

/* File: rtl/ext_clk_counter.sv */
`timescale 1ns/10ps
module ext_clk_counter #(
	parameter int WIDTH = gpio_rail_pkg::GRAY_W
) (
	// link clock and reset
	input  wire logic             ext_clk_in,
	input  wire logic             rst_in,
	// gray-coded edge count toward the core domain
	output logic [WIDTH-1:0]      gray_count_out
);

	logic [WIDTH-1:0] bin_ff;
	logic [WIDTH-1:0] nxt_bin;
	logic [1:0]       rst_sync_ff;
	logic             link_rst;

	// reset leaves the link domain only in step with the link clock
	always_ff @(posedge ext_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_sync_ff <= 2'h3;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b0};
		end
	end

	assign link_rst = rst_sync_ff[1];
	assign nxt_bin  = bin_ff + {{(WIDTH-1){1'b0}}, 1'b1};

	// only one bit changes per edge, so the core can sample it safely
	always_ff @(posedge ext_clk_in or posedge link_rst) begin
		if (link_rst) begin
			bin_ff         <= '0;
			gray_count_out <= '0;
		end else begin
			bin_ff         <= nxt_bin;
			gray_count_out <= nxt_bin ^ (nxt_bin >> 1);
		end
	end

endmodule : ext_clk_counter

/* File: testbench/serial_host.sv */
`timescale 1ns/10ps
module serial_host (
	// core clock
	input  wire logic clock_in,
	// bus lines, sda open drain with pull-up
	input  wire logic sda_line_in,
	output logic      scl_out,
	output logic      sda_pull_out
);
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// 8 core cycles per phase, twice the minimum low/high time
	task automatic wt();
		repeat (8) @(negedge clock_in);
	endtask : wt
	task automatic start();
		sda_pull_out = 1'b0;
		wt();
		scl_out = 1'b1;
		wt();
		sda_pull_out = 1'b1;
		wt();
		scl_out = 1'b0;
		wt();
	endtask : start
	task automatic stop();
		sda_pull_out = 1'b1;
		wt();
		scl_out = 1'b1;
		wt();
		sda_pull_out = 1'b0;
		wt();
	endtask : stop
	// eight bits msb first plus the ack slot; a 1 releases the line
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_pull_out = !d[i];
			wt();
			scl_out = 1'b1;
			wt();
			q[i] = sda_line_in;
			scl_out = 1'b0;
			wt();
		end
		sda_pull_out = 1'b0;
	endtask : xfer
endmodule : serial_host

/* File: testbench/rail_controller_gpio_functions_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module rail_controller_gpio_functions_test;
	logic                        clock_in, rst_in, ext_clk_in, otp_load_in, serial_mode_in;
	logic                        sda_out, sda_oe_out, scl, sda_pull, ext_clk_req_out;
	logic [5:0]                  gpio_in, gpio_out, gpio_oe_out, otp_polarity_in;
	gpio_rail_pkg::pin_cfg_s [5:0] otp_pin_cfg_in;
	logic [6:0]                  otp_slave_addr_in;
	logic [4:0]                  rail_good_in, rail_enable_out;
	gpio_rail_pkg::event_vec_s   events_in;
	logic [3:0][8:0]             phase_deg_out;
	logic [2:0]                  ext_clk_pin_out;
	logic [8:0]                  q;
	logic [7:0]                  rv;
	int                          n_errors, checks_done;
	localparam logic [6:0] ADDR = 7'h31;
	wire sda_line = (sda_oe_out ? sda_out : 1'b1) & !sda_pull;
	gpio_rail_ctrl dut_u (.clock_in(clock_in), .rst_in(rst_in), .ext_clk_in(ext_clk_in),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
		.otp_load_in(otp_load_in), .otp_polarity_in(otp_polarity_in),
		.otp_pin_cfg_in(otp_pin_cfg_in), .otp_slave_addr_in(otp_slave_addr_in),
		.serial_mode_in(serial_mode_in), .rail_good_in(rail_good_in), .events_in(events_in),
		.rail_enable_out(rail_enable_out), .phase_deg_out(phase_deg_out),
		.ext_clk_pin_out(ext_clk_pin_out), .ext_clk_req_out(ext_clk_req_out));
	serial_host host_u (.clock_in(clock_in), .sda_line_in(sda_line), .scl_out(scl),
		.sda_pull_out(sda_pull));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	// link clock runs free, phase unrelated to the core clock
	initial begin
		ext_clk_in = 1'b0;
		#1.3;
		forever #3 ext_clk_in = ~ext_clk_in;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask : cyc
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		host_u.start();
		host_u.xfer({ADDR, 2'b01}, q);
		`CHK(q[0], 1'b0)
		host_u.xfer({r, 1'b1}, q);
		host_u.xfer({d, 1'b1}, q);
		host_u.stop();
	endtask : wr
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		host_u.start();
		host_u.xfer({ADDR, 2'b01}, q);
		host_u.xfer({r, 1'b1}, q);
		host_u.start();
		host_u.xfer({ADDR, 2'b11}, q);
		host_u.xfer(9'h1FF, q);
		d = q[8:1];
		host_u.stop();
	endtask : rd
	task automatic t_reset();
		`CHK(rail_enable_out, 5'h00)
		`CHK(gpio_oe_out, 6'h00)
		`CHK(phase_deg_out, {9'h10E, 9'h0B4, 9'h05A, 9'h000})
	endtask : t_reset
	task automatic t_otp();
		otp_polarity_in = 6'h01;
		otp_slave_addr_in = ADDR;
		otp_pin_cfg_in[0] = {gpio_rail_pkg::FN_RAIL_EN, 5'h11};
		otp_pin_cfg_in[1] = {gpio_rail_pkg::FN_PWR_GOOD, 5'h03};
		otp_pin_cfg_in[2] = {gpio_rail_pkg::FN_EVENT, 5'h08};
		otp_pin_cfg_in[3] = {gpio_rail_pkg::FN_EXT_CLK, 5'h00};
		otp_load_in = 1'b1;
		cyc(1);
		otp_load_in = 1'b0;
		cyc(6);
		`CHK(rail_enable_out, 5'h11)
		gpio_in[0] = 1'b1;
		cyc(6);
		`CHK(rail_enable_out, 5'h00)
		`CHK({ext_clk_req_out, ext_clk_pin_out}, 4'hB)
		rd(gpio_rail_pkg::REG_SLAVE_ADDR, rv);
		`CHK(rv, 8'h31)
		host_u.start();
		host_u.xfer({7'h20, 2'b01}, q);
		`CHK(q[0], 1'b1)
		host_u.stop();
	endtask : t_otp
	task automatic t_pins();
		rail_good_in = 5'h03;
		events_in = 18'h00100;
		cyc(5);
		`CHK(gpio_out[2:1], 2'h3)
		`CHK(gpio_oe_out[2:1], 2'h3)
		rail_good_in = 5'h1D;
		events_in = 18'h3FEFF;
		cyc(5);
		`CHK(gpio_out[2:1], 2'h0)
		rd(gpio_rail_pkg::REG_RAIL_GOOD, rv);
		`CHK(rv, 8'h1D)
		rd(gpio_rail_pkg::REG_EVENT_MID, rv);
		`CHK(rv, 8'hFE)
	endtask : t_pins
	task automatic t_host();
		wr(gpio_rail_pkg::REG_HOST_RAIL_EN, 8'h04);
		cyc(3);
		`CHK(rail_enable_out, 5'h04)
		gpio_in[0] = 1'b0;
		cyc(6);
		`CHK(rail_enable_out, 5'h15)
		rd(gpio_rail_pkg::REG_RAIL_EN_STAT, rv);
		`CHK(rv, 8'h15)
	endtask : t_host
	task automatic t_phase();
		wr(gpio_rail_pkg::REG_PHASE_MODE, 8'h01);
		// channels 0 and 3 share a step on purpose; channel 2 uses selector 3
		wr(gpio_rail_pkg::REG_PHASE_SEL, 8'hB6);
		cyc(3);
		`CHK(phase_deg_out, {9'h0F0, 9'h000, 9'h078, 9'h0F0})
		wr(gpio_rail_pkg::REG_PHASE_MODE, 8'h00);
		cyc(3);
		`CHK(phase_deg_out, {9'h0B4, 9'h10E, 9'h05A, 9'h0B4})
	endtask : t_phase
	task automatic t_pol();
		wr(gpio_rail_pkg::REG_FUNC_BASE + 8'h04, {gpio_rail_pkg::FN_OUTPUT, 5'h00});
		wr(gpio_rail_pkg::REG_POLARITY, 8'h3F);
		rd(gpio_rail_pkg::REG_POLARITY, rv);
		`CHK(rv, 8'h0F)
		`CHK(gpio_oe_out[4], 1'b0)
		serial_mode_in = 1'b0;
		wr(gpio_rail_pkg::REG_POLARITY, 8'h3E);
		rd(gpio_rail_pkg::REG_POLARITY, rv);
		`CHK(rv, 8'h3E)
		wr(gpio_rail_pkg::REG_OUT_LEVEL, 8'h10);
		cyc(3);
		`CHK({gpio_oe_out[5:4], gpio_out[5:4]}, 4'h6)
		// 256 core cycles of 4 ns against a 6 ns link clock
		rd(gpio_rail_pkg::REG_EXT_CLK_CNT, rv);
		`CHK((rv == 8'hAA) || (rv == 8'hAB), 1'b1)
	endtask : t_pol
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	initial begin
		#150000;
		n_errors++;
		summarize();
	end
	initial begin
		rst_in = 1'b1;
		otp_load_in = 1'b0;
		serial_mode_in = 1'b1;
		gpio_in = 6'h00;
		otp_polarity_in = 6'h00;
		otp_pin_cfg_in = '0;
		otp_slave_addr_in = 7'h00;
		rail_good_in = 5'h00;
		events_in = '0;
		n_errors = 0;
		checks_done = 0;
		cyc(10);
		rst_in = 1'b0;
		cyc(4);
		t_reset();
		t_otp();
		t_pins();
		t_host();
		t_phase();
		t_pol();
		summarize();
	end
endmodule : rail_controller_gpio_functions_test
